// *** core/cssp_pkg.sv ***
// Purpose: Shared constants and types for the status word and setup-pointer bank
// Assumes: 16-bit data port, 8-bit index port
// Notes: Bits 15..11 of the status word are kept outside this block and read as zero
package cssp_pkg;

  // ==========================================================================
  // Register indices, selected through the index port
  localparam logic [7:0] CSSP_IDX_CTRL = 8'h00;
  localparam logic [7:0] CSSP_IDX_PTR_LO = 8'h01;
  localparam logic [7:0] CSSP_IDX_PTR_HI = 8'h02;
  localparam logic [7:0] CSSP_IDX_PTR_LO_ALIAS = 8'h10;
  localparam logic [7:0] CSSP_IDX_PTR_HI_ALIAS = 8'h11;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CSSP_IDX_RESET = 8'h00;
  localparam logic [15:0] CSSP_DATA_ZERO = 16'h0000;

  // Data port selector values
  localparam logic CSSP_SEL_INDEX = 1'b0;
  localparam logic CSSP_SEL_DATA = 1'b1;

  // ==========================================================================
  // Status and control word layout, bit 15 downward
  typedef struct packed {
    logic [4:0] reserved;
    logic rx_done_flag;
    logic tx_done_flag;
    logic setup_done_flag;
    logic irq_summary_flag;
    logic irq_master_enable;
    logic rx_active;
    logic tx_active;
    logic tx_poll_now;
    logic halt;
    logic run_request;
    logic setup_request;
  } cssp_ctrl_t;

  // Events and levels reported by the buffer manager and the rest of the chip
  typedef struct packed {
    logic rx_frame_done;
    logic tx_frame_done;
    logic tx_frame_ok;
    logic setup_read_done;
    logic tx_underrun;
    logic tx_desc_fetch;
    logic system_error_flag;
    logic sleep_event_flag;
  } cssp_events_t;

  // Configuration levels held in other registers of the device
  typedef struct packed {
    logic tx_done_mask;
    logic setup_done_mask;
    logic rx_done_mask;
    logic tx_ok_irq_suppress;
    logic rx_disable;
    logic tx_disable;
    logic keep_tx_on_underrun;
    logic suspend_state;
    logic wide_structures;
  } cssp_config_t;

  // Engine states, Gray along halt -> setup -> run
  typedef enum logic [1:0] {
    CSSP_ST_HALT = 2'b00,
    CSSP_ST_SETUP = 2'b01,
    CSSP_ST_RUN = 2'b11,
    CSSP_ST_IDLE = 2'b10
  } cssp_state_t;

endpackage

// *** core/cssp_regs.sv ***
// Purpose: Status/control word and setup-block pointer words behind an index/data port pair
// Assumes: Single clock, synchronous active-low reset, strobes are one-cycle pulses
// Notes: Pointer words keep their contents through reset
`timescale 1ns/10ps
`default_nettype none

module cssp_regs (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Host index/data port
  input wire logic i_port_sel,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  // Events and configuration
  input wire cssp_pkg::cssp_events_t i_events,
  input wire cssp_pkg::cssp_config_t i_config,
  // Engine control
  output logic o_inta_b,
  output logic o_halted,
  output logic o_setup_fetch,
  output logic o_dma_run,
  output logic o_rx_enable,
  output logic o_tx_enable,
  output logic o_tx_poll_now,
  // Setup address and address extension
  output logic [31:0] o_setup_addr,
  output logic [7:0] o_addr_ext_byte,
  output logic o_addr_ext_force
);
  import cssp_pkg::*;

  // ==========================================================================
  // State
  logic [7:0] index_q;
  logic [7:0] index_d;
  cssp_state_t state_q;
  cssp_state_t state_d;
  logic run_pend_q;
  logic run_pend_d;
  cssp_ctrl_t ctrl_q;
  cssp_ctrl_t ctrl_d;
  logic [15:0] ptr_lo_q;
  logic [15:0] ptr_hi_q;
  logic [15:0] rdata_q;
  logic inta_b_q;
  logic setup_fetch_q;
  logic dma_run_q;
  logic ext_force_q;

  // ==========================================================================
  // Port decode
  wire data_wr = i_wr_stb & (i_port_sel == CSSP_SEL_DATA);
  wire index_wr = i_wr_stb & (i_port_sel == CSSP_SEL_INDEX);
  wire data_rd = i_rd_stb & (i_port_sel == CSSP_SEL_DATA);
  wire sel_ctrl = (index_q == CSSP_IDX_CTRL);
  wire sel_lo = (index_q == CSSP_IDX_PTR_LO) | (index_q == CSSP_IDX_PTR_LO_ALIAS);
  wire sel_hi = (index_q == CSSP_IDX_PTR_HI) | (index_q == CSSP_IDX_PTR_HI_ALIAS);
  wire ptr_open = ctrl_q.halt | i_config.suspend_state;
  cssp_ctrl_t wr_bits;
  assign wr_bits = cssp_ctrl_t'(i_wdata);
  wire ctrl_wr = data_wr & sel_ctrl;

  // Command decode; halt overrides run and setup written with it
  wire halt_w = ctrl_wr & wr_bits.halt;
  wire run_w = ctrl_wr & wr_bits.run_request & ~wr_bits.halt;
  wire setup_w = ctrl_wr & wr_bits.setup_request & ~wr_bits.halt;

  // ==========================================================================
  // Event qualification
  wire rx_done_set = i_events.rx_frame_done;
  wire tx_done_set = i_events.tx_frame_done
                   & ~(i_events.tx_frame_ok & i_config.tx_ok_irq_suppress);
  wire setup_done_set = i_events.setup_read_done & (state_q == CSSP_ST_SETUP);
  wire tx_drop = i_events.tx_underrun & ~i_config.keep_tx_on_underrun;

  // Engine sequencing: setup first, then run if it was asked for or the engine was already running
  always_comb
  begin
    state_d = state_q;
    run_pend_d = run_pend_q | run_w;
    if (halt_w)
    begin
      state_d = CSSP_ST_HALT;
      run_pend_d = 1'b0;
    end
    else if (setup_w && state_q != CSSP_ST_SETUP)
    begin
      state_d = CSSP_ST_SETUP;
      run_pend_d = run_w | (state_q == CSSP_ST_RUN);
    end
    else if (state_q == CSSP_ST_SETUP)
    begin
      if (i_events.setup_read_done)
      begin
        state_d = run_pend_d ? CSSP_ST_RUN : CSSP_ST_IDLE;
        run_pend_d = 1'b0;
      end
    end
    else if (run_w)
    begin
      state_d = CSSP_ST_RUN;
      run_pend_d = 1'b0;
    end
  end

  wire go_run = (state_d == CSSP_ST_RUN) & (state_q != CSSP_ST_RUN);
  wire in_run = (state_d == CSSP_ST_RUN);

  // Summary of permitted causes and interrupt pin level
  wire irq_causes = (ctrl_d.rx_done_flag & ~i_config.rx_done_mask)
                  | (ctrl_d.tx_done_flag & ~i_config.tx_done_mask)
                  | (ctrl_d.setup_done_flag & ~i_config.setup_done_mask)
                  | i_events.system_error_flag | i_events.sleep_event_flag;
  wire force_irq = i_events.system_error_flag | i_events.sleep_event_flag;
  wire inta_d = ~((irq_causes & ctrl_d.irq_master_enable) | force_irq);

  // ==========================================================================
  // Next value of the status and control word
  always_comb
  begin
    ctrl_d = ctrl_q;
    ctrl_d.reserved = '0;
    // Write-one clears; a set in the same cycle wins
    ctrl_d.rx_done_flag = rx_done_set
                        | (ctrl_q.rx_done_flag & ~(ctrl_wr & wr_bits.rx_done_flag));
    ctrl_d.tx_done_flag = tx_done_set
                        | (ctrl_q.tx_done_flag & ~(ctrl_wr & wr_bits.tx_done_flag));
    ctrl_d.setup_done_flag = setup_done_set
                           | (ctrl_q.setup_done_flag & ~(ctrl_wr & wr_bits.setup_done_flag));
    if (ctrl_wr)
    begin
      ctrl_d.irq_master_enable = wr_bits.irq_master_enable;
    end
    if (run_w)
    begin
      ctrl_d.run_request = 1'b1;
      ctrl_d.halt = 1'b0;
    end
    if (setup_w)
    begin
      ctrl_d.setup_request = 1'b1;
      ctrl_d.halt = 1'b0;
    end
    // Active bits follow entry into the running state
    if (go_run)
    begin
      ctrl_d.rx_active = ~i_config.rx_disable;
      ctrl_d.tx_active = ~i_config.tx_disable;
    end
    else if (!in_run)
    begin
      ctrl_d.rx_active = 1'b0;
      ctrl_d.tx_active = 1'b0;
    end
    if (tx_drop)
    begin
      ctrl_d.tx_active = 1'b0;
    end
    // Poll demand: set by write-one, cleared on fetch or when transmit is off
    ctrl_d.tx_poll_now = ((ctrl_wr & wr_bits.tx_poll_now)
                         | (ctrl_q.tx_poll_now & ~i_events.tx_desc_fetch))
                         & ctrl_d.tx_active;
    if (halt_w)
    begin
      ctrl_d.halt = 1'b1;
      ctrl_d.run_request = 1'b0;
      ctrl_d.setup_request = 1'b0;
      ctrl_d.rx_done_flag = 1'b0;
      ctrl_d.tx_done_flag = 1'b0;
      ctrl_d.setup_done_flag = 1'b0;
      ctrl_d.irq_master_enable = 1'b0;
      ctrl_d.rx_active = 1'b0;
      ctrl_d.tx_active = 1'b0;
      ctrl_d.tx_poll_now = 1'b0;
    end
    ctrl_d.irq_summary_flag = 1'b0;
  end

  // Index port
  assign index_d = index_wr ? i_wdata[7:0] : index_q;

  // ==========================================================================
  // Control registers with reset
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      index_q <= CSSP_IDX_RESET;
      state_q <= CSSP_ST_HALT;
      run_pend_q <= 1'b0;
      ctrl_q <= cssp_ctrl_t'(CSSP_DATA_ZERO);
      ctrl_q.halt <= 1'b1;
      inta_b_q <= 1'b1;
      setup_fetch_q <= 1'b0;
      dma_run_q <= 1'b0;
      ext_force_q <= 1'b0;
    end
    else
    begin
      index_q <= index_d;
      state_q <= state_d;
      run_pend_q <= run_pend_d;
      ctrl_q <= ctrl_d;
      inta_b_q <= inta_d;
      setup_fetch_q <= (state_d == CSSP_ST_SETUP);
      dma_run_q <= in_run;
      ext_force_q <= ~i_config.wide_structures;
    end
  end

  // Pointer words keep their value through reset and halt
  always_ff @(posedge i_clk_sys)
  begin
    if (data_wr && ptr_open && sel_lo)
    begin
      ptr_lo_q <= i_wdata;
    end
    if (data_wr && ptr_open && sel_hi)
    begin
      ptr_hi_q <= i_wdata;
    end
  end

  // ==========================================================================
  // Read path; summary is computed live from the stored causes and the live system and sleep events
  cssp_ctrl_t ctrl_view;
  always_comb
  begin
    ctrl_view = ctrl_q;
    ctrl_view.irq_summary_flag = (ctrl_q.rx_done_flag & ~i_config.rx_done_mask)
                               | (ctrl_q.tx_done_flag & ~i_config.tx_done_mask)
                               | (ctrl_q.setup_done_flag & ~i_config.setup_done_mask)
                               | i_events.system_error_flag
                               | i_events.sleep_event_flag;
  end

  wire [15:0] rd_mux = sel_ctrl ? 16'(ctrl_view)
                     : (sel_lo && ptr_open) ? ptr_lo_q
                     : (sel_hi && ptr_open) ? ptr_hi_q
                     : CSSP_DATA_ZERO;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      rdata_q <= CSSP_DATA_ZERO;
    end
    else if (data_rd)
    begin
      rdata_q <= rd_mux;
    end
    else if (i_rd_stb)
    begin
      rdata_q <= {CSSP_DATA_ZERO[15:8], index_q};
    end
  end

  // ==========================================================================
  // Outputs
  assign o_rdata = rdata_q;
  assign o_inta_b = inta_b_q;
  assign o_halted = ctrl_q.halt;
  assign o_setup_fetch = setup_fetch_q;
  assign o_dma_run = dma_run_q;
  assign o_rx_enable = ctrl_q.rx_active;
  assign o_tx_enable = ctrl_q.tx_active;
  assign o_tx_poll_now = ctrl_q.tx_poll_now;
  assign o_setup_addr = {ptr_hi_q, ptr_lo_q};
  assign o_addr_ext_byte = ptr_hi_q[15:8];
  assign o_addr_ext_force = ext_force_q;

endmodule // cssp_regs

`default_nettype wire

// *** dv/cssp_bufmgr_model.sv ***
// Purpose: Buffer manager stand-in that answers setup reads and poll demands
// Assumes: Completion outputs are one-cycle pulses
// Notes: i_slow stretches the setup read so both quick and slow answers occur
`timescale 1ns/10ps
`default_nettype none

module cssp_bufmgr_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Requests from the block
  input wire logic i_setup_fetch,
  input wire logic i_poll_now,
  input wire logic i_slow,
  // Completion pulses
  output logic o_setup_read_done,
  output logic o_tx_desc_fetch
);
  logic [3:0] cnt_q;

  // ==========================================================================
  // Setup read ends after 3 or 10 cycles; a poll demand gets one ring fetch
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b || !i_setup_fetch)
    begin
      cnt_q <= 4'h0;
    end
    else
    begin
      cnt_q <= cnt_q + 4'h1;
    end
    o_setup_read_done <= i_rst_b && i_setup_fetch && (cnt_q == (i_slow ? 4'h9 : 4'h2));
    o_tx_desc_fetch <= i_rst_b && i_poll_now && !o_tx_desc_fetch;
  end
endmodule // cssp_bufmgr_model

`default_nettype wire

// *** dv/cssp_regs_properties.sv ***
// Purpose: Timing relations of the status word at the block's ports
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every cssp_regs instance
`timescale 1ns/10ps
`default_nettype none

module cssp_regs_properties
  import cssp_pkg::*;
(
  // Clock, reset and host port
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_port_sel,
  input wire logic i_wr_stb,
  input wire logic [15:0] i_wdata,
  // Events and configuration
  input wire cssp_pkg::cssp_events_t i_events,
  input wire cssp_pkg::cssp_config_t i_config,
  // Observed outputs
  input wire logic o_inta_b,
  input wire logic o_halted,
  input wire logic o_setup_fetch,
  input wire logic o_dma_run,
  input wire logic o_rx_enable,
  input wire logic o_tx_enable,
  input wire logic o_tx_poll_now
);
  logic [7:0] idx_q;
  wire ctrl_wr = i_wr_stb && i_port_sel == CSSP_SEL_DATA && idx_q == CSSP_IDX_CTRL;

  // ==========================================================================
  // Index shadow, so status word writes can be recognised
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      idx_q <= CSSP_IDX_RESET;
    end
    else if (i_wr_stb && i_port_sel == CSSP_SEL_INDEX)
    begin
      idx_q <= i_wdata[7:0];
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  // Setup plus run from halt, then the end of the block read
  sequence s_setup_run;
    ctrl_wr && i_wdata[2:0] == 3'b011 && o_halted;
  endsequence
  sequence s_setup_end;
    o_setup_fetch && i_events.setup_read_done && !i_wr_stb;
  endsequence

  halt_wins_a:
    assert property (ctrl_wr && i_wdata[2] |=> o_halted && !o_dma_run && !o_tx_poll_now)
    else $error("halt write did not stop the engine");
  run_from_halt_a:
    assert property (ctrl_wr && i_wdata[2:0] == 3'b010 && o_halted |=>
      !o_halted && o_dma_run && o_tx_enable == !$past(i_config.tx_disable))
    else $error("run write did not start the engine");
  setup_first_a:
    assert property (s_setup_run |=> o_setup_fetch && !o_tx_enable && !o_rx_enable)
    else $error("actives set before setup read");
  setup_then_run_a:
    assert property (s_setup_run ##[1:30] s_setup_end |=>
      o_dma_run && o_rx_enable == !$past(i_config.rx_disable))
    else $error("no run after setup read");
  underrun_stop_a:
    assert property (o_tx_enable && i_events.tx_underrun && !i_config.keep_tx_on_underrun
      |=> !o_tx_enable)
    else $error("underrun left transmit active");
  poll_fetch_a:
    assert property (i_events.tx_desc_fetch && !ctrl_wr |=> !o_tx_poll_now)
    else $error("poll demand survived fetch");
  poll_idle_a:
    assert property (!o_tx_enable |-> !o_tx_poll_now)
    else $error("poll demand held while transmit idle");
  syserr_irq_a:
    assert property (i_events.system_error_flag || i_events.sleep_event_flag |=> !o_inta_b)
    else $error("interrupt missing for system event");
endmodule // cssp_regs_properties

bind cssp_regs cssp_regs_properties cssp_regs_properties_inst (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_port_sel(i_port_sel), .i_wr_stb(i_wr_stb),
  .i_wdata(i_wdata), .i_events(i_events), .i_config(i_config), .o_inta_b(o_inta_b),
  .o_halted(o_halted), .o_setup_fetch(o_setup_fetch), .o_dma_run(o_dma_run),
  .o_rx_enable(o_rx_enable), .o_tx_enable(o_tx_enable), .o_tx_poll_now(o_tx_poll_now));

`default_nettype wire

// *** dv/tb.sv ***
// Purpose: Random and corner-case bench for the status word and pointer bank
// Assumes: Host port driven on rising edges
// Notes: Buffer manager stand-in answers setup reads and poll demands
`timescale 1ns/10ps
`default_nettype none

module tb;
  import cssp_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, sel = 1'b0, wr = 1'b0, rd_s = 1'b0, slow = 1'b0, ok;
  logic [15:0] wd = 16'h0000, rdat, r;
  logic [31:0] ptr, addr;
  logic [7:0] ext;
  logic inta_b, halted, fetch, run, rx_en, tx_en, poll, force_ext, srd, dfe;
  cssp_events_t ev = '0, ev_in;
  cssp_config_t cfg = '0;
  int seed = 46697, errors = 0, compares = 0;

  // ==========================================================================
  // Clock, and partner pulses merged into the event bus
  always #5 clk = ~clk;
  assign ev_in = {ev[7:5], srd, ev[3], dfe, ev[1:0]};

  cssp_regs cssp_regs_inst (.i_clk_sys(clk), .i_rst_b(rst_b), .i_port_sel(sel), .i_wr_stb(wr),
    .i_rd_stb(rd_s), .i_wdata(wd), .o_rdata(rdat), .i_events(ev_in), .i_config(cfg),
    .o_inta_b(inta_b), .o_halted(halted), .o_setup_fetch(fetch), .o_dma_run(run),
    .o_rx_enable(rx_en), .o_tx_enable(tx_en), .o_tx_poll_now(poll), .o_setup_addr(addr),
    .o_addr_ext_byte(ext), .o_addr_ext_force(force_ext));
  cssp_bufmgr_model cssp_bufmgr_model_inst (.i_clk_sys(clk), .i_rst_b(rst_b),
    .i_setup_fetch(fetch), .i_poll_now(poll), .i_slow(slow), .o_setup_read_done(srd),
    .o_tx_desc_fetch(dfe));

  // ==========================================================================
  // Expected status word after setup plus run, and interrupt after a sent frame
  function automatic logic [15:0] ctrl_exp(input cssp_config_t c);
    ctrl_exp = {7'h00, 1'b1, !c.setup_done_mask, 1'b0, !c.rx_disable, !c.tx_disable, 4'h3};
  endfunction
  function automatic logic inta_exp(input logic k, input cssp_config_t c);
    inta_exp = !(!(k && c.tx_ok_irq_suppress) && !c.tx_done_mask);
  endfunction

  // Host port cycles and comparison
  task automatic put(input logic s, input logic [15:0] d);
    @(posedge clk);
    sel <= s;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] i, input logic [15:0] d);
    put(CSSP_SEL_INDEX, {8'h00, i});
    put(CSSP_SEL_DATA, d);
  endtask
  task automatic reg_rd(input logic [7:0] i, output logic [15:0] d);
    put(CSSP_SEL_INDEX, {8'h00, i});
    @(posedge clk);
    sel <= CSSP_SEL_DATA;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #100000;
    errors++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    reg_rd(CSSP_IDX_CTRL, r);
    chk(r, 16'h0004);
    chk(inta_b, 1'b1);
    ptr = $random(seed);
    ptr[1:0] = 2'b00;
    reg_wr(CSSP_IDX_PTR_LO, ptr[15:0]);
    reg_wr(CSSP_IDX_PTR_HI_ALIAS, ptr[31:16]);
    reg_rd(CSSP_IDX_PTR_LO_ALIAS, r);
    chk(r, ptr[15:0]);
    reg_rd(CSSP_IDX_PTR_HI, r);
    chk(r, ptr[31:16]);
    chk(addr, ptr);
    chk(ext, ptr[31:24]);
    chk(force_ext, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      cfg <= cssp_config_t'((9'($random(seed)) & (k == 0 ? 9'h1A0 : 9'h1B8))
        | (k == 2 ? 9'h004 : k == 1 ? 9'h001 : 9'h000)); // Keep bit, wide mode
      slow <= k[0];
      reg_wr(CSSP_IDX_CTRL, 16'h0004);
      reg_wr(CSSP_IDX_CTRL, 16'h0003);
      #1 chk(fetch, 1'b1);
      chk(tx_en, 1'b0);
      repeat (40) if (!run) @(negedge clk);
      reg_rd(CSSP_IDX_CTRL, r);
      chk(r, ctrl_exp(cfg));
      chk(force_ext, !cfg.wide_structures);
      reg_wr(CSSP_IDX_PTR_LO, {~ptr[15:2], 2'b00});
      reg_rd(CSSP_IDX_PTR_LO, r);
      chk(r, 16'h0000);
      ok = 1'($random(seed));
      reg_wr(CSSP_IDX_CTRL, 16'h0140);
      ev.tx_frame_done <= 1'b1;
      ev.tx_frame_ok <= ok;
      @(posedge clk);
      ev <= '0;
      repeat (2) @(negedge clk);
      chk(inta_b, inta_exp(ok, cfg));
      reg_wr(CSSP_IDX_CTRL, 16'h0240);
      repeat (2) @(negedge clk);
      chk(inta_b, 1'b1);
      // Received frame raises the interrupt until written back as one
      @(posedge clk);
      ev.rx_frame_done <= 1'b1;
      @(posedge clk);
      ev <= '0;
      repeat (2) @(negedge clk);
      chk(inta_b, 1'b0);
      reg_wr(CSSP_IDX_CTRL, 16'h0440);
      repeat (2) @(negedge clk);
      chk(inta_b, 1'b1);
      reg_wr(CSSP_IDX_CTRL, 16'h0048);
      #1 chk(poll, !cfg.tx_disable);
      repeat (4) @(negedge clk);
      chk(poll, 1'b0);
      @(posedge clk);
      ev.tx_underrun <= 1'b1;
      @(posedge clk);
      ev.tx_underrun <= 1'b0;
      #1 chk(tx_en, cfg.keep_tx_on_underrun && !cfg.tx_disable);
      reg_wr(CSSP_IDX_CTRL, 16'h0000);
      ev.system_error_flag <= 1'b1;
      repeat (2) @(negedge clk);
      chk(inta_b, 1'b0);
      @(posedge clk);
      ev.system_error_flag <= 1'b0;
      reg_wr(CSSP_IDX_CTRL, 16'h0007);
      reg_rd(CSSP_IDX_CTRL, r);
      chk(r, 16'h0004);
      reg_rd(CSSP_IDX_PTR_LO_ALIAS, r);
      chk(r, ptr[15:0]);
    end
    // Plain run from halt, pointers opened by suspend, then setup alone
    reg_wr(CSSP_IDX_CTRL, 16'h0002);
    #1 chk(run, 1'b1);
    chk(halted, 1'b0);
    chk(rx_en, !cfg.rx_disable);
    @(posedge clk);
    cfg.suspend_state <= 1'b1;
    reg_wr(CSSP_IDX_PTR_LO, {~ptr[15:2], 2'b00});
    reg_rd(CSSP_IDX_PTR_LO_ALIAS, r);
    chk(r, {~ptr[15:2], 2'b00});
    reg_wr(CSSP_IDX_CTRL, 16'h0004);
    #1 chk(halted, 1'b1);
    reg_wr(CSSP_IDX_CTRL, 16'h0001);
    repeat (20) @(negedge clk);
    chk(run, 1'b0);
    reg_rd(CSSP_IDX_CTRL, r);
    chk(r, {8'h01, !cfg.setup_done_mask, 7'h01});
    reg_wr(CSSP_IDX_CTRL, 16'h0002);
    #1 chk(tx_en, !cfg.tx_disable);
    summarize();
  end
endmodule // tb

`default_nettype wire
